// ### include/dpgsf_pkg.sv
// Purpose: shared constants and types of the global control command path
// Assumes: one clock domain, group mask of eight bits
// Notes:   function codes and broadcast control byte layout live here
`default_nettype none

package dpgsf_pkg;

   localparam int unsigned NUM_GROUPS = 8;
   localparam int unsigned FUNC_W     = 8;
   localparam int unsigned RESULT_W   = 8;

   // function codes of the channel_control_instruction
   localparam logic [FUNC_W-1:0] FC_FREEZE   = 8'h0d;
   localparam logic [FUNC_W-1:0] FC_UNFREEZE = 8'h0e;
   localparam logic [FUNC_W-1:0] FC_SYNC     = 8'h0f;
   localparam logic [FUNC_W-1:0] FC_UNSYNC   = 8'h10;

   // bit positions in the broadcast control byte
   localparam int unsigned GC_BIT_UNFREEZE = 2;
   localparam int unsigned GC_BIT_FREEZE   = 3;
   localparam int unsigned GC_BIT_UNSYNC   = 4;
   localparam int unsigned GC_BIT_SYNC     = 5;

   // reset values
   localparam logic [RESULT_W-1:0]   RESULT_RST = 8'h00;
   localparam logic [NUM_GROUPS-1:0] GROUP_RST  = 8'h00;
   localparam logic [7:0]            CTRL_RST   = 8'h00;

   typedef enum logic [2:0] {
      KIND_NONE     = 3'b000,
      KIND_FREEZE   = 3'b001,
      KIND_UNFREEZE = 3'b010,
      KIND_SYNC     = 3'b011,
      KIND_UNSYNC   = 3'b100
   } dpgsf_kind_type;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } dpgsf_state_type;

   function automatic dpgsf_kind_type dpgsf_decode(
      input logic [FUNC_W-1:0] func);
      dpgsf_kind_type k;
      k = KIND_NONE;
      if (func == FC_FREEZE) begin
         k = KIND_FREEZE;
      end else if (func == FC_UNFREEZE) begin
         k = KIND_UNFREEZE;
      end else if (func == FC_SYNC) begin
         k = KIND_SYNC;
      end else if (func == FC_UNSYNC) begin
         k = KIND_UNSYNC;
      end
      return k;
   endfunction

   function automatic logic [7:0] dpgsf_ctrl_byte(input dpgsf_kind_type k);
      logic [7:0] b;
      b = CTRL_RST;
      unique case (k)
         KIND_FREEZE:   b[GC_BIT_FREEZE]   = 1'b1;
         KIND_UNFREEZE: b[GC_BIT_UNFREEZE] = 1'b1;
         KIND_SYNC:     b[GC_BIT_SYNC]     = 1'b1;
         KIND_UNSYNC:   b[GC_BIT_UNSYNC]   = 1'b1;
         default:       b = CTRL_RST;
      endcase
      return b;
   endfunction

endpackage

`default_nettype wire

// ### verilog/dpgsf_group_state.sv
// Purpose: per-group sync and freeze state of the addressed slave groups
// Assumes: done pulses arrive only when the broadcast has been carried out
// Notes:   all outputs registered; one generate slice per group
`default_nettype none

module dpgsf_group_state
   import dpgsf_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  cmd_done,
   input  wire dpgsf_kind_type        cmd_kind,
   input  wire logic [NUM_GROUPS-1:0] cmd_mask,
   input  wire logic                  data_exch,
   output logic      [NUM_GROUPS-1:0] sync_active,
   output logic      [NUM_GROUPS-1:0] freeze_active,
   output logic      [NUM_GROUPS-1:0] out_apply,
   output logic      [NUM_GROUPS-1:0] out_store,
   output logic      [NUM_GROUPS-1:0] out_update,
   output logic      [NUM_GROUPS-1:0] in_latch,
   output logic      [NUM_GROUPS-1:0] in_live
);

   logic [NUM_GROUPS-1:0] sync_d, freeze_d, apply_d, store_d, update_d;
   logic [NUM_GROUPS-1:0] latch_d, live_d;

   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      logic hit;
      assign hit = cmd_done && cmd_mask[g];
      always_comb begin
         sync_d[g]   = sync_active[g];
         freeze_d[g] = freeze_active[g];
         apply_d[g]  = 1'b0;
         latch_d[g]  = 1'b0;
         if (hit && cmd_kind == KIND_SYNC) begin
            // hold outputs; a repeat sync also applies the stored image
            apply_d[g] = sync_active[g]; // [R15]
            sync_d[g]  = 1'b1; // [R11]
         end
         if (hit && cmd_kind == KIND_UNSYNC) begin
            apply_d[g] = sync_active[g]; // [R13]
            sync_d[g]  = 1'b0; // [R14]
         end
         if (hit && cmd_kind == KIND_FREEZE) begin
            latch_d[g]  = 1'b1; // [R16]
            freeze_d[g] = 1'b1; // [R16]
         end
         if (hit && cmd_kind == KIND_UNFREEZE) begin
            freeze_d[g] = 1'b0; // [R18]
         end
         store_d[g]  = data_exch && sync_active[g]; // [R12]
         update_d[g] = data_exch && !sync_active[g]; // [R14]
         // while frozen the exchange returns the latched inputs
         live_d[g]   = !freeze_d[g]; // [R17]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_active   <= GROUP_RST;
         freeze_active <= GROUP_RST;
         out_apply     <= GROUP_RST;
         out_store     <= GROUP_RST;
         out_update    <= GROUP_RST;
         in_latch      <= GROUP_RST;
         in_live       <= ~GROUP_RST;
      end else if (ce) begin
         sync_active   <= sync_d;
         freeze_active <= freeze_d;
         out_apply     <= apply_d;
         out_store     <= store_d;
         out_update    <= update_d;
         in_latch      <= latch_d;
         in_live       <= live_d;
      end
   end

endmodule // dpgsf_group_state

`default_nettype wire

// ### verilog/dpgsf_ctrl.sv
// Purpose: command interpreter for global sync, unsync, freeze, unfreeze
// Assumes: host gives function code and group mask with a one-cycle strobe
// Notes:   one broadcast per command, busy until the link acknowledges it
`default_nettype none

// Operation
// [R01] code 15 starts Sync, code 16 starts Unsync to the masked groups
// [R02] Unsync is decoded apart from Sync but uses the same mask path
// [R03] code 13 starts Freeze, code 14 starts Unfreeze to masked groups
// [R04] parameter is an eight-bit mask, group n on bit n-1
// [R05] at most eight groups, any number of slaves per group
// [R06] busy flag rises as soon as a global command starts
// [R07] on completion busy drops and the response code is loaded
// [R08] host issues a command only while busy reads low
// [R09] error flag set when the channel is not assigned
// [R10] command while busy sets error and is not started
// [R11] Sync makes the selected slaves hold their outputs together
// [R12] exchanges during Sync store the image without applying it
// [R13] Unsync applies all pending outputs at one common instant
// [R14] after Unsync outputs update on every normal exchange again
// [R15] repeated Sync applies the current image to all addressed outputs
// [R16] Freeze latches inputs at one instant, later changes ignored
// [R17] next exchange after Freeze returns the latched inputs
// [R18] after Unfreeze slaves report live inputs again
// [R19] host waits a delay after Freeze before using frozen inputs
// [R20] one command goes out as a single broadcast to all masked groups
module dpgsf_ctrl
   import dpgsf_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // host side
   input  wire logic                  cmd_valid,
   input  wire logic [FUNC_W-1:0]     cmd_func,
   input  wire logic [NUM_GROUPS-1:0] cmd_mask,
   input  wire logic                  channel_assigned,
   output logic                       global_command_busy_flag,
   output logic                       error_flag,
   output logic      [RESULT_W-1:0]   result,
   output logic                       cmd_done,
   // bus link side
   output logic                       gc_valid,
   output logic      [7:0]            gc_ctrl,
   output logic      [NUM_GROUPS-1:0] gc_groups,
   input  wire logic                  gc_ack,
   input  wire logic [RESULT_W-1:0]   gc_status,
   input  wire logic                  data_exch,
   // per-group state toward the cyclic exchange
   output logic      [NUM_GROUPS-1:0] sync_active,
   output logic      [NUM_GROUPS-1:0] freeze_active,
   output logic      [NUM_GROUPS-1:0] out_apply,
   output logic      [NUM_GROUPS-1:0] out_store,
   output logic      [NUM_GROUPS-1:0] out_update,
   output logic      [NUM_GROUPS-1:0] in_latch,
   output logic      [NUM_GROUPS-1:0] in_live
);

   dpgsf_state_type       state_q, state_d;
   dpgsf_kind_type        kind_q, kind_d;
   dpgsf_kind_type        req_kind;
   logic                  busy_q, busy_d;
   logic                  err_q, err_d;
   logic [RESULT_W-1:0]   result_q, result_d;
   logic                  done_q, done_d;
   logic                  gc_valid_q, gc_valid_d;
   logic [7:0]            gc_ctrl_q, gc_ctrl_d;
   logic [NUM_GROUPS-1:0] gc_groups_q, gc_groups_d;
   logic                  req_global;

   // decode of the request itself
   always_comb begin
      req_kind   = dpgsf_decode(cmd_func); // [R01] [R03]
      req_global = cmd_valid && (req_kind != KIND_NONE); // [R02]
   end

   // error flag: set on any refused command, cleared by an accepted one
   always_comb begin
      err_d = err_q;
      if (req_global) begin
         if (state_q == ST_SEND) begin
            // overlapping command is refused and flagged
            err_d = 1'b1; // [R10]
         end else if (!channel_assigned) begin
            err_d = 1'b1; // [R09]
         end else begin
            err_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         err_q <= 1'b0;
      end else if (ce) begin
         err_q <= err_d;
      end
   end

   // response code is captured only when the link acknowledges
   always_comb begin
      result_d = result_q;
      if (state_q == ST_SEND && gc_ack) begin
         result_d = gc_status; // [R07]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         result_q <= RESULT_RST;
      end else if (ce) begin
         result_q <= result_d;
      end
   end

   // next-state logic of the command sequencer
   always_comb begin
      state_d     = state_q;
      kind_d      = kind_q;
      busy_d      = busy_q;
      done_d      = 1'b0;
      gc_valid_d  = gc_valid_q;
      gc_ctrl_d   = gc_ctrl_q;
      gc_groups_d = gc_groups_q;
      unique case (state_q)
         ST_IDLE: begin
            if (req_global && channel_assigned) begin
               busy_d      = 1'b1; // [R06]
               kind_d      = req_kind;
               // single broadcast carrying the whole mask
               gc_valid_d  = 1'b1; // [R20]
               gc_ctrl_d   = dpgsf_ctrl_byte(req_kind); // [R02]
               gc_groups_d = cmd_mask; // [R04] [R05]
               state_d     = ST_SEND;
            end
         end
         ST_SEND: begin
            if (gc_ack) begin
               gc_valid_d = 1'b0;
               busy_d     = 1'b0; // [R07]
               done_d     = 1'b1;
               state_d    = ST_IDLE;
            end
         end
         default: begin
            state_d    = ST_IDLE;
            busy_d     = 1'b0;
            gc_valid_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q     <= ST_IDLE;
         kind_q      <= KIND_NONE;
         busy_q      <= 1'b0;
         done_q      <= 1'b0;
         gc_valid_q  <= 1'b0;
         gc_ctrl_q   <= CTRL_RST;
         gc_groups_q <= GROUP_RST;
      end else if (ce) begin
         state_q     <= state_d;
         kind_q      <= kind_d;
         busy_q      <= busy_d;
         done_q      <= done_d;
         gc_valid_q  <= gc_valid_d;
         gc_ctrl_q   <= gc_ctrl_d;
         gc_groups_q <= gc_groups_d;
      end
   end

   assign global_command_busy_flag = busy_q;
   assign error_flag               = err_q;
   assign result                   = result_q;
   assign cmd_done                 = done_q;
   assign gc_valid                 = gc_valid_q;
   assign gc_ctrl                  = gc_ctrl_q;
   assign gc_groups                = gc_groups_q;

   // group effects take hold together when the broadcast completes
   dpgsf_group_state u_groups (
      .clock         (clock),
      .rst           (rst),
      .ce            (ce),
      .cmd_done      (done_q), // [R13] [R16]
      .cmd_kind      (kind_q),
      .cmd_mask      (gc_groups_q),
      .data_exch     (data_exch),
      .sync_active   (sync_active),
      .freeze_active (freeze_active),
      .out_apply     (out_apply),
      .out_store     (out_store),
      .out_update    (out_update),
      .in_latch      (in_latch),
      .in_live       (in_live)
   );

endmodule // dpgsf_ctrl

`default_nettype wire

// ### tb/dpgsf_ctrl_props.sv
// Purpose: concurrent checks on the global command interpreter
// Assumes: ce high while commands run
// Notes:   bound to dpgsf_ctrl after the module
`default_nettype none
module dpgsf_ctrl_props
   import dpgsf_pkg::*;
(
   input wire logic             clock,
   input wire logic             rst,
   input wire logic             ce,
   input wire logic             cmd_valid,
   input wire logic [FUNC_W-1:0] cmd_func,
   input wire logic [7:0]       cmd_mask,
   input wire logic             channel_assigned,
   input wire logic             global_command_busy_flag,
   input wire logic             error_flag,
   input wire logic [7:0]       result,
   input wire logic             cmd_done,
   input wire logic             gc_valid,
   input wire logic [7:0]       gc_ctrl,
   input wire logic [7:0]       gc_groups,
   input wire logic             gc_ack,
   input wire logic [7:0]       gc_status,
   input wire logic             data_exch,
   input wire logic [7:0]       sync_active,
   input wire logic [7:0]       freeze_active,
   input wire logic [7:0]       out_store,
   input wire logic [7:0]       out_update,
   input wire logic [7:0]       in_latch,
   input wire logic [7:0]       in_live
);
   logic go;
   logic bz;
   assign go = ce && cmd_valid && cmd_func >= FC_FREEZE
               && cmd_func <= FC_UNSYNC;
   assign bz = global_command_busy_flag;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_ack(c);
      ce && gc_valid && gc_ack && gc_ctrl == c ##1 cmd_done;
   endsequence
   a_accept_busy: assert property (go && !bz && channel_assigned |=>
      bz && gc_valid && gc_groups == $past(cmd_mask)) else $error("no start");
   a_ctrl_code: assert property (go && !bz && channel_assigned |=>
      gc_ctrl == ($past(cmd_func) == FC_SYNC ? 8'h20 :
      $past(cmd_func) == FC_UNSYNC ? 8'h10 :
      $past(cmd_func) == FC_FREEZE ? 8'h08 : 8'h04)) else $error("bad code");
   a_done_load: assert property (ce && gc_valid && gc_ack |=> cmd_done &&
      !bz && result == $past(gc_status)) else $error("no completion");
   a_no_channel: assert property (go && !bz && !channel_assigned |=>
      error_flag && !bz) else $error("unassigned taken");
   a_busy_refuse: assert property (go && bz && !gc_ack |=>
      error_flag && bz) else $error("busy refusal");
   a_sync_hold: assert property (s_ack(8'h20) |=>
      (sync_active & $past(gc_groups, 2)) == $past(gc_groups, 2))
      else $error("sync hold");
   a_unsync_free: assert property (s_ack(8'h10) |=>
      (sync_active & $past(gc_groups, 2)) == 8'h00) else $error("unsync");
   a_freeze_latch: assert property (s_ack(8'h08) |=>
      in_latch == $past(gc_groups, 2)) else $error("freeze latch");
   a_exch_route: assert property (ce && data_exch |=>
      out_store == $past(sync_active) && out_update == ~$past(sync_active))
      else $error("exchange route");
   a_live_view: assert property (in_live == ~freeze_active)
      else $error("live view");
endmodule // dpgsf_ctrl_props
bind dpgsf_ctrl dpgsf_ctrl_props u_props (.clock, .rst, .ce, .cmd_valid,
   .cmd_func, .cmd_mask, .channel_assigned, .global_command_busy_flag,
   .error_flag, .result, .cmd_done, .gc_valid, .gc_ctrl, .gc_groups,
   .gc_ack, .gc_status, .data_exch, .sync_active, .freeze_active,
   .out_store, .out_update, .in_latch, .in_live);
`default_nettype wire

// ### tb/dpgsf_link_model.sv
// Purpose: slave-side link model answering each broadcast once
// Assumes: slow selects a long answer
// Notes:   status idles toggling, valid only with the ack pulse
`default_nettype none
module dpgsf_link_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       slow,
   input  wire logic       gc_valid,
   input  wire logic [7:0] gc_groups,
   output logic            gc_ack,
   output logic      [7:0] gc_status
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt       <= 4'h0;
         gc_ack    <= 1'b0;
         gc_status <= 8'h00;
      end else begin
         gc_ack    <= 1'b0;
         gc_status <= ~gc_status;
         if (gc_valid && !gc_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == (slow ? 4'h6 : 4'h1)) begin
               cnt       <= 4'h0;
               gc_ack    <= 1'b1;
               gc_status <= gc_groups ^ 8'h5a;
            end
         end
      end
   end
endmodule // dpgsf_link_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: directed test of the global command interpreter
// Assumes: link model answers each broadcast
// Notes:   result expected as mask xor 5a
`default_nettype none
module tb
   import dpgsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, cmd_valid = 0, chan = 1, dx = 0, slow = 0;
   logic [7:0] cmd_func = 0, cmd_mask = 0;
   logic busy, err, done, gcv, ack;
   logic [7:0] res, gcc, gcg, gst, sa, fa, oa, os, ou, il, ilv;
   int failures = 0, checked = 0;
   always #2.5 clock = ~clock;
   dpgsf_ctrl DUT (.clock(clock), .rst(rst), .ce(1'b1),
      .cmd_valid(cmd_valid), .cmd_func(cmd_func), .cmd_mask(cmd_mask),
      .channel_assigned(chan), .global_command_busy_flag(busy),
      .error_flag(err), .result(res), .cmd_done(done), .gc_valid(gcv),
      .gc_ctrl(gcc), .gc_groups(gcg), .gc_ack(ack), .gc_status(gst),
      .data_exch(dx), .sync_active(sa), .freeze_active(fa),
      .out_apply(oa), .out_store(os), .out_update(ou), .in_latch(il),
      .in_live(ilv));
   dpgsf_link_model u_link (.clock(clock), .rst(rst), .slow(slow),
      .gc_valid(gcv), .gc_groups(gcg), .gc_ack(ack), .gc_status(gst));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic pulse(input logic [7:0] f, m, input logic a);
      @(posedge clock);
      cmd_valid <= 1;
      cmd_func  <= f;
      cmd_mask  <= m;
      chan      <= a;
      @(posedge clock);
      cmd_valid <= 0;
      #1;
   endtask
   task automatic finish_cmd(input logic [7:0] m);
      int i;
      for (i = 0; i < 40 && busy === 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      if (i == 40) begin
         failures++;
         end_of_test();
      end
      check({7'h0, done}, 8'h01);
      check(res, m ^ 8'h5a);
      @(posedge clock);
      #1;
   endtask
   task automatic run(input logic [7:0] f, m, c);
      pulse(f, m, 1);
      check({7'h0, busy}, 8'h01);
      check({7'h0, gcv}, 8'h01);
      check(gcc, c);
      check(gcg, m);
      finish_cmd(m);
   endtask
   task automatic exch;
      @(posedge clock);
      dx <= 1;
      @(posedge clock);
      dx <= 0;
      #1;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 0;
      #1;
      check(ilv, 8'hff);
      check(sa, 8'h00);
      run(FC_SYNC, 8'h04, 8'h20);
      check(sa, 8'h04);
      exch();
      check(os, 8'h04);
      check(ou, 8'hfb);
      slow <= 1;
      pulse(FC_SYNC, 8'h04, 1);
      pulse(FC_FREEZE, 8'hff, 1);
      check({7'h0, err}, 8'h01);
      check(gcc, 8'h20);
      finish_cmd(8'h04);
      check(oa, 8'h04);
      slow <= 0;
      run(FC_UNSYNC, 8'h04, 8'h10);
      check(oa, 8'h04);
      check(sa, 8'h00);
      exch();
      check(ou, 8'hff);
      repeat (2) begin
         run(FC_FREEZE, 8'h10, 8'h08);
         check(il, 8'h10);
         // host lets the latched inputs come back before using them
         repeat (4) @(posedge clock);
         #1;
         check(fa, 8'h10);
         check(ilv, 8'hef);
      end
      run(FC_UNFREEZE, 8'h10, 8'h04);
      check(fa, 8'h00);
      check(ilv, 8'hff);
      pulse(FC_SYNC, 8'h01, 0);
      check({7'h0, err}, 8'h01);
      check({7'h0, busy}, 8'h00);
      pulse(8'h0c, 8'h01, 1);
      check({7'h0, busy}, 8'h00);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
